// ===== rtl/mtsc_consts.vh
// constants for the multidrop transmit slot coordinator
`ifndef MTSC_CONSTS_VH
`define MTSC_CONSTS_VH

// register offsets (byte addresses) and fields
`define MTSC_CTRL_OFFSET 8'h00
`define MTSC_STATUS_OFFSET 8'h04
`define MTSC_CTRL_EN_BIT 0
`define MTSC_CTRL_RESET 32'h0000_0000
`define MTSC_ST_CSTATE_LSB 0
`define MTSC_ST_DSTATE_LSB 4
`define MTSC_ST_SLOT_LSB 8
`define MTSC_ST_FW_BIT 16

// default durations, in transmit clock periods (nibbles)
`define MTSC_SLOT_TICKS 16'h0020
`define MTSC_SILENCE_TICKS 16'h0080
`define MTSC_EARLY_RX_TICKS 16'h0010
`define MTSC_MARKER_TICKS 16'h0008
`define MTSC_OWN_NODE 8'h00
`define MTSC_MAX_NODES 8'h08

// delay line storage
`define MTSC_DL_DEPTH 128
`define MTSC_DL_AW 7

// special signalling codes on the data nibble
`define MTSC_CODE_MARKER 4'h2
`define MTSC_CODE_CLAIM 4'h3

// control part states
`define MTSC_C_DISABLED 4'h0
`define MTSC_C_RESYNCHRONISE_STATE 4'h1
`define MTSC_C_RECOVER 4'h2
`define MTSC_C_SEND_MARKER 4'h3
`define MTSC_C_SYNCING 4'h4
`define MTSC_C_SLOT_WAIT 4'h5
`define MTSC_C_EARLY_RX 4'h6
`define MTSC_C_RECEIVE 4'h7
`define MTSC_C_CLAIM 4'h8
`define MTSC_C_TRANSMIT 4'h9

// data part states
`define MTSC_D_IDLE 3'h0
`define MTSC_D_HOLD 3'h1
`define MTSC_D_TRANSMIT 3'h2
`define MTSC_D_RECEIVE 3'h3
`define MTSC_D_COLLIDE 3'h4
`define MTSC_D_PENDING 3'h5
`define MTSC_D_ABORT 3'h6

`endif

// ===== rtl/mtsc_top.v
// multidrop transmit slot coordinator: control part, data part, delay line, apb registers
//
// Contract
// - while disabled, slot variables sit at defaults and no special command is sent
// - node zero, when enabled, waits for silence then sends a cycle marker
// - nonzero nodes, when enabled, wait in resynchronise until a cycle marker
// - slot timer restarts only after the cycle marker has ended
// - after synchronisation the slot counter clears and the slot timer starts
// - early receive in slot wait enters early receive, arms its timer, stops slot timer
// - early receive goes to receive on carrier, to resynchronise on a cycle marker
// - early receive timeout starts recovery: node zero resends marker, others wait
// - carrier in slot wait enters receive at once and stops the slot timer
// - at own slot, frame waiting claims the slot, otherwise the slot is yielded
// - slot timer expiry increments the slot counter and restarts the timer
// - idle data part waits for mac transmission, early receive or carrier
// - mac transmission enters hold and delays data; carrier first reports carrier
// - mac transmission racing a carrier gives a logical collision, nothing forwarded
// - hold sets frame waiting and keeps the frame start in the delay line
// - slot claimed while holding enters transmit and sends delayed data
// - delay line holds at most slot time times nodes plus marker time
// - transmit error during hold aborts, clears frame waiting, frame never sent
// - another node transmitting while data is held gives a logical collision
// - collide clears frame waiting, reports carrier, then pending after the jam
// - pending sets frame waiting, holds carrier, drops carrier at own slot
// - carrier flag from tx enable, rx valid, collision and crs; early flag is crs
// - receive command is cycle marker while the phy indication lasts
// - disabled block behaves as a plain mii reconciliation layer
`timescale 1ns/1ps
`include "mtsc_consts.vh"

module mtsc_top #(
    parameter [15:0] SLOT_TICKS = `MTSC_SLOT_TICKS,
    parameter [15:0] SILENCE_TICKS = `MTSC_SILENCE_TICKS,
    parameter [15:0] EARLY_RX_TICKS = `MTSC_EARLY_RX_TICKS,
    parameter [15:0] MARKER_TICKS = `MTSC_MARKER_TICKS,
    parameter [7:0] OWN_NODE_NUMBER = `MTSC_OWN_NODE,
    parameter [7:0] MAX_NODE_COUNT = `MTSC_MAX_NODES
) (
    input wire CLOCK,
    input wire RST_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output wire [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    input wire TX_CLK,
    input wire [3:0] MAC_TXD,
    input wire MAC_TX_EN,
    input wire MAC_TX_ER,
    output wire MAC_CRS,
    output wire MAC_COL,
    output wire [3:0] PHY_TXD,
    output wire PHY_TX_EN,
    output wire PHY_TX_ER,
    input wire PHY_CRS,
    input wire PHY_COL,
    input wire PHY_RX_DV,
    input wire PHY_RX_ER,
    input wire [3:0] PHY_RXD
);

    // delay line limit in nibbles, capped by storage
    localparam integer DL_WANT = SLOT_TICKS * MAX_NODE_COUNT + MARKER_TICKS;
    localparam integer DL_LIM_I = (DL_WANT > `MTSC_DL_DEPTH) ? `MTSC_DL_DEPTH : DL_WANT;
    localparam [7:0] DL_LIMIT = DL_LIM_I[7:0];

    // input synchronisers: three flops, value accepted when stages two and three agree
    wire [14:0] raw_in;
    reg [14:0] s1_q;
    reg [14:0] s2_q;
    reg [14:0] s3_q;
    reg [14:0] f_q;
    assign raw_in = {TX_CLK, MAC_TX_EN, MAC_TX_ER, MAC_TXD, PHY_CRS, PHY_COL, PHY_RX_DV,
                     PHY_RX_ER, PHY_RXD};
    genvar gi;
    generate
        for (gi = 0; gi < 15; gi = gi + 1) begin : g_sync
            always @(posedge CLOCK or negedge RST_N) begin
                if (!RST_N) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    f_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= raw_in[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        f_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate

    wire tclk = f_q[14];
    wire m_tx_en = f_q[13];
    wire m_tx_er = f_q[12];
    wire [3:0] m_txd = f_q[11:8];
    wire p_crs = f_q[7];
    wire p_col = f_q[6];
    wire p_rx_dv = f_q[5];
    wire p_rx_er = f_q[4];
    wire [3:0] p_rxd = f_q[3:0];

    // tick on falling edge of the transmit clock: mac data is stable mid-period
    reg tclk_prev_q;
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            tclk_prev_q <= 1'b0;
        end else begin
            tclk_prev_q <= tclk;
        end
    end
    wire tick = tclk_prev_q & ~tclk;

    // apb registers
    reg ctrl_en_q;
    reg [31:0] prdata_q;
    reg [3:0] cst_q;
    reg [2:0] dst_q;
    reg [7:0] slot_counter_q;
    wire frame_waiting;
    wire hit_ctrl = (PADDR == `MTSC_CTRL_OFFSET);
    wire hit_stat = (PADDR == `MTSC_STATUS_OFFSET);
    wire [31:0] status_word = ({28'h000_0000, cst_q} << `MTSC_ST_CSTATE_LSB)
                            | ({29'h0000_0000, dst_q} << `MTSC_ST_DSTATE_LSB)
                            | ({24'h00_0000, slot_counter_q} << `MTSC_ST_SLOT_LSB)
                            | ({31'h0000_0000, frame_waiting} << `MTSC_ST_FW_BIT);
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~hit_ctrl & ~hit_stat;
    assign PRDATA = prdata_q;
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_en_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            if (PSEL & ~PENABLE & ~PWRITE) begin
                if (hit_ctrl) begin
                    prdata_q <= {31'h0000_0000, ctrl_en_q};
                end else if (hit_stat) begin
                    prdata_q <= status_word;
                end else begin
                    prdata_q <= 32'h0000_0000;
                end
            end
            if (PSEL & PENABLE & PWRITE & hit_ctrl) begin
                ctrl_en_q <= PWDATA[`MTSC_CTRL_EN_BIT];
            end
        end
    end
    wire en = ctrl_en_q;

    // carrier, early receive and receive command decode
    wire plca_crs = PHY_TX_EN | p_rx_dv | (~p_col & p_crs);
    wire eri = p_crs;
    wire rx_marker = ~p_rx_dv & p_rx_er & (p_rxd == `MTSC_CODE_MARKER);

    // control part
    reg [3:0] cst_d;
    reg [15:0] timer_q;
    reg [15:0] timer_d;
    reg [7:0] slot_counter_d;
    wire [7:0] slot_next = slot_counter_q + 8'h01;
    wire timer_zero = (timer_q == 16'h0000);
    wire committed = (cst_q == `MTSC_C_CLAIM);

    always @* begin
        cst_d = cst_q;
        timer_d = timer_q;
        slot_counter_d = slot_counter_q;
        if (!en) begin
            cst_d = `MTSC_C_DISABLED;
            timer_d = 16'h0000;
            slot_counter_d = 8'h00;
        end else begin
            case (cst_q)
                `MTSC_C_DISABLED: begin
                    if (OWN_NODE_NUMBER == 8'h00) begin
                        cst_d = `MTSC_C_RECOVER;
                        timer_d = SILENCE_TICKS;
                    end else begin
                        cst_d = `MTSC_C_RESYNCHRONISE_STATE;
                    end
                end
                `MTSC_C_RESYNCHRONISE_STATE: begin
                    if (rx_marker) begin
                        cst_d = `MTSC_C_SYNCING;
                    end
                end
                `MTSC_C_RECOVER: begin
                    if (plca_crs) begin
                        timer_d = SILENCE_TICKS;
                    end else if (timer_zero) begin
                        cst_d = `MTSC_C_SEND_MARKER;
                        timer_d = MARKER_TICKS;
                    end else if (tick) begin
                        timer_d = timer_q - 16'h0001;
                    end
                end
                `MTSC_C_SEND_MARKER: begin
                    if (timer_zero) begin
                        cst_d = `MTSC_C_SYNCING;
                    end else if (tick) begin
                        timer_d = timer_q - 16'h0001;
                    end
                end
                `MTSC_C_SYNCING: begin
                    if (!rx_marker) begin
                        cst_d = `MTSC_C_SLOT_WAIT;
                        slot_counter_d = 8'h00;
                        timer_d = SLOT_TICKS;
                    end
                end
                `MTSC_C_SLOT_WAIT: begin
                    if (eri & ~plca_crs) begin
                        cst_d = `MTSC_C_EARLY_RX;
                        timer_d = EARLY_RX_TICKS;
                    end else if (plca_crs) begin
                        cst_d = `MTSC_C_RECEIVE;
                    end else if ((slot_counter_q == OWN_NODE_NUMBER) & frame_waiting) begin
                        cst_d = `MTSC_C_CLAIM;
                    end else if (timer_zero) begin
                        slot_counter_d = slot_next;
                        timer_d = SLOT_TICKS;
                        if (slot_next >= MAX_NODE_COUNT) begin
                            cst_d = (OWN_NODE_NUMBER == 8'h00) ? `MTSC_C_SEND_MARKER
                                                               : `MTSC_C_RESYNCHRONISE_STATE;
                            timer_d = MARKER_TICKS;
                        end
                    end else if (tick) begin
                        timer_d = timer_q - 16'h0001;
                    end
                end
                `MTSC_C_EARLY_RX: begin
                    if (rx_marker) begin
                        cst_d = `MTSC_C_RESYNCHRONISE_STATE;
                    end else if (plca_crs) begin
                        cst_d = `MTSC_C_RECEIVE;
                    end else if (timer_zero) begin
                        if (OWN_NODE_NUMBER == 8'h00) begin
                            cst_d = `MTSC_C_RECOVER;
                            timer_d = SILENCE_TICKS;
                        end else begin
                            cst_d = `MTSC_C_RESYNCHRONISE_STATE;
                        end
                    end else if (tick) begin
                        timer_d = timer_q - 16'h0001;
                    end
                end
                `MTSC_C_RECEIVE, `MTSC_C_TRANSMIT: begin
                    if (rx_marker) begin
                        cst_d = `MTSC_C_RESYNCHRONISE_STATE;
                    end else if ((cst_q == `MTSC_C_RECEIVE) ? ~plca_crs
                                 : (dst_q != `MTSC_D_TRANSMIT)) begin
                        slot_counter_d = slot_next;
                        cst_d = `MTSC_C_SLOT_WAIT;
                        timer_d = SLOT_TICKS;
                        if (slot_next >= MAX_NODE_COUNT) begin
                            cst_d = (OWN_NODE_NUMBER == 8'h00) ? `MTSC_C_SEND_MARKER
                                                               : `MTSC_C_RESYNCHRONISE_STATE;
                            timer_d = MARKER_TICKS;
                        end
                    end
                end
                `MTSC_C_CLAIM: begin
                    if (dst_q == `MTSC_D_TRANSMIT) begin
                        cst_d = `MTSC_C_TRANSMIT;
                    end else if (dst_q == `MTSC_D_ABORT) begin
                        cst_d = `MTSC_C_SLOT_WAIT;
                        timer_d = 16'h0000;
                    end
                end
                default: begin
                    cst_d = `MTSC_C_DISABLED;
                end
            endcase
        end
    end

    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cst_q <= `MTSC_C_DISABLED;
            timer_q <= 16'h0000;
            slot_counter_q <= 8'h00;
        end else begin
            cst_q <= cst_d;
            timer_q <= timer_d;
            slot_counter_q <= slot_counter_d;
        end
    end

    // data part
    reg [2:0] dst_d;
    reg [4:0] dl_mem [0:`MTSC_DL_DEPTH-1];
    reg [`MTSC_DL_AW-1:0] wp_q;
    reg [`MTSC_DL_AW-1:0] rp_q;
    reg [7:0] cnt_q;
    wire phy_busy = p_rx_dv | p_crs;
    assign frame_waiting = en & ((dst_q == `MTSC_D_HOLD) | (dst_q == `MTSC_D_PENDING));

    always @* begin
        dst_d = dst_q;
        if (!en) begin
            dst_d = `MTSC_D_IDLE;
        end else begin
            case (dst_q)
                `MTSC_D_IDLE: begin
                    if (m_tx_en) begin
                        dst_d = phy_busy ? `MTSC_D_COLLIDE : `MTSC_D_HOLD;
                    end else if (eri | p_rx_dv) begin
                        dst_d = `MTSC_D_RECEIVE;
                    end
                end
                `MTSC_D_RECEIVE: begin
                    if (~eri & ~p_rx_dv) begin
                        dst_d = `MTSC_D_IDLE;
                    end
                end
                `MTSC_D_HOLD: begin
                    if (m_tx_er) begin
                        dst_d = `MTSC_D_ABORT;
                    end else if (committed & tick) begin
                        dst_d = `MTSC_D_TRANSMIT;
                    end else if (cst_q == `MTSC_C_RECEIVE) begin
                        dst_d = `MTSC_D_COLLIDE;
                    end
                end
                `MTSC_D_TRANSMIT: begin
                    if (~m_tx_en & (cnt_q == 8'h00) & tick) begin
                        dst_d = `MTSC_D_IDLE;
                    end
                end
                `MTSC_D_COLLIDE: begin
                    if (~m_tx_en) begin
                        dst_d = `MTSC_D_PENDING;
                    end
                end
                `MTSC_D_PENDING: begin
                    if (committed) begin
                        dst_d = `MTSC_D_IDLE;
                    end
                end
                `MTSC_D_ABORT: begin
                    if (~m_tx_en) begin
                        dst_d = `MTSC_D_IDLE;
                    end
                end
                default: begin
                    dst_d = `MTSC_D_IDLE;
                end
            endcase
        end
    end

    // delay line: written while holding or sending, read while sending
    wire dl_wr = tick & m_tx_en & (cnt_q < DL_LIMIT)
               & ((dst_q == `MTSC_D_HOLD) | (dst_q == `MTSC_D_TRANSMIT));
    wire dl_rd = tick & (dst_q == `MTSC_D_TRANSMIT) & (cnt_q != 8'h00);
    wire dl_flush = (dst_q != `MTSC_D_HOLD) & (dst_q != `MTSC_D_TRANSMIT);
    always @(posedge CLOCK) begin
        if (dl_wr) begin
            dl_mem[wp_q] <= {m_tx_er, m_txd};
        end
    end
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            dst_q <= `MTSC_D_IDLE;
            wp_q <= {`MTSC_DL_AW{1'b0}};
            rp_q <= {`MTSC_DL_AW{1'b0}};
            cnt_q <= 8'h00;
        end else begin
            dst_q <= dst_d;
            if (dl_flush) begin
                wp_q <= {`MTSC_DL_AW{1'b0}};
                rp_q <= {`MTSC_DL_AW{1'b0}};
                cnt_q <= 8'h00;
            end else begin
                if (dl_wr) begin
                    wp_q <= wp_q + 1'b1;
                end
                if (dl_rd) begin
                    rp_q <= rp_q + 1'b1;
                end
                if (dl_wr & ~dl_rd) begin
                    cnt_q <= cnt_q + 8'h01;
                end else if (dl_rd & ~dl_wr) begin
                    cnt_q <= cnt_q - 8'h01;
                end
            end
        end
    end

    // mii outputs toward the phy, updated once per transmit clock period
    reg [3:0] txd_q;
    reg tx_en_q;
    reg tx_er_q;
    reg [4:0] dl_out;
    always @* begin
        dl_out = dl_mem[rp_q];
    end
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            txd_q <= 4'h0;
            tx_en_q <= 1'b0;
            tx_er_q <= 1'b0;
        end else if (tick) begin
            if (!en) begin
                txd_q <= m_txd;
                tx_en_q <= m_tx_en;
                tx_er_q <= m_tx_er;
            end else if (dl_rd) begin
                txd_q <= dl_out[3:0];
                tx_en_q <= 1'b1;
                tx_er_q <= dl_out[4];
            end else if (cst_q == `MTSC_C_SEND_MARKER) begin
                txd_q <= `MTSC_CODE_MARKER;
                tx_en_q <= 1'b0;
                tx_er_q <= 1'b1;
            end else if (committed & (dst_q != `MTSC_D_TRANSMIT)) begin
                txd_q <= `MTSC_CODE_CLAIM;
                tx_en_q <= 1'b0;
                tx_er_q <= 1'b1;
            end else begin
                txd_q <= 4'h0;
                tx_en_q <= 1'b0;
                tx_er_q <= 1'b0;
            end
        end
    end
    assign PHY_TXD = txd_q;
    assign PHY_TX_EN = tx_en_q;
    assign PHY_TX_ER = tx_er_q;

    // carrier and collision toward the mac
    reg crs_q;
    reg col_q;
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            crs_q <= 1'b0;
            col_q <= 1'b0;
        end else if (!en) begin
            crs_q <= p_crs;
            col_q <= p_col;
        end else begin
            crs_q <= (dst_q == `MTSC_D_RECEIVE) | (dst_q == `MTSC_D_COLLIDE)
                   | ((dst_q == `MTSC_D_PENDING) & ~committed);
            col_q <= (dst_q == `MTSC_D_COLLIDE);
        end
    end
    assign MAC_CRS = crs_q;
    assign MAC_COL = col_q;

endmodule // mtsc_top

// ===== test/mtsc_phy_model.sv
// behavioural phy on the far side of the mii
`timescale 1ns/1ps
module mtsc_phy_model (
    input wire [3:0] txd,
    input wire tx_en,
    input wire tx_er,
    input wire carrier,
    output logic tx_clk,
    output logic crs,
    output logic col,
    output logic rx_dv,
    output logic rx_er,
    output logic [3:0] rxd,
    output int n_mark,
    output int n_mstart,
    output int n_claim,
    output int n_data,
    output logic [31:0] data_q
);
    logic was_mark = 1'b0;
    initial {tx_clk, crs, col, rx_dv, rx_er, rxd} = 9'h000;
    always #80 tx_clk = ~tx_clk;
    // line sampled at the rising edge
    always @(posedge tx_clk) begin
        was_mark <= !tx_en && tx_er && txd == 4'h2;
        if (!tx_en && tx_er && txd == 4'h2) n_mark++;
        if (!tx_en && tx_er && txd == 4'h2 && !was_mark) n_mstart++;
        if (!tx_en && tx_er && txd == 4'h3) n_claim++;
        if (tx_en) n_data++;
        if (tx_en) data_q <= {data_q[27:0], txd};
    end
    // receive status launched mid period; idle data line keeps toggling
    always @(negedge tx_clk) begin
        crs <= carrier;
        rx_dv <= carrier;
        col <= 1'b0;
        rx_er <= 1'b0;
        rxd <= carrier ? rxd + 4'h1 : ~rxd;
    end
endmodule // mtsc_phy_model

// ===== test/mtsc_top_sva.sv
// assertions on the slot coordinator top ports
`timescale 1ns/1ps
module mtsc_top_sva (
    input wire CLOCK,
    input wire RST_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire MAC_TX_EN,
    input wire MAC_TX_ER,
    input wire MAC_CRS,
    input wire MAC_COL,
    input wire [3:0] PHY_TXD,
    input wire PHY_TX_EN,
    input wire PHY_TX_ER,
    input wire PHY_CRS,
    input wire PHY_COL
);
    logic en_q;
    logic [5:0] dis_q;
    // shadow of the enable bit and a count of quiet disabled cycles
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            en_q <= 1'b0;
            dis_q <= 6'h00;
        end else begin
            if (PSEL && PENABLE && PWRITE && PADDR == 8'h00) en_q <= PWDATA[0];
            dis_q <= (en_q || MAC_TX_ER) ? 6'h00 : dis_q + {5'h00, dis_q != 6'h3f};
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    sequence s_crs_held;
        (PHY_CRS && !PHY_COL && !MAC_TX_EN) [*8];
    endsequence
    chk_ready_high: assert property (PSEL |-> PREADY)
        else $error("pready low during a transfer");
    chk_err_unmapped: assert property (PSEL && PENABLE |-> PSLVERR == (PADDR != 8'h00 && PADDR != 8'h04))
        else $error("pslverr does not match the address");
    chk_idle_plain: assert property (dis_q == 6'h3f |-> !PHY_TX_ER)
        else $error("special signalling while disabled");
    chk_crs_follow: assert property (s_crs_held |=> MAC_CRS)
        else $error("carrier not reported to the mac");
    chk_code_valid: assert property (en_q && !PHY_TX_EN && PHY_TX_ER |-> PHY_TXD[3:1] == 3'h1)
        else $error("unknown special code");
    chk_col_carrier: assert property (en_q && MAC_COL |-> MAC_CRS)
        else $error("collision without carrier");
    chk_col_no_data: assert property (en_q && MAC_COL |-> !PHY_TX_EN)
        else $error("data forwarded during collision");
    chk_nibble_stands: assert property ($changed(PHY_TXD) |=> $stable(PHY_TXD) [*8])
        else $error("nibble changed within a period");
endmodule // mtsc_top_sva
bind mtsc_top mtsc_top_sva i_sva (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .MAC_TX_EN(MAC_TX_EN), .MAC_TX_ER(MAC_TX_ER), .MAC_CRS(MAC_CRS), .MAC_COL(MAC_COL),
    .PHY_TXD(PHY_TXD), .PHY_TX_EN(PHY_TX_EN), .PHY_TX_ER(PHY_TX_ER), .PHY_CRS(PHY_CRS),
    .PHY_COL(PHY_COL));

// ===== test/testbench.sv
// self-checking bench for the slot coordinator
`timescale 1ns/1ps
`include "mtsc_consts.vh"
`define CHK(nm, ex, ac) begin num_checks++; if ((ac) !== (ex)) begin n_mismatch++; \
    $display("wrong value %s expected %h seen %h", nm, ex, ac); end end
module testbench;
    logic CLOCK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, MAC_TX_EN = 0;
    logic MAC_TX_ER = 0, carrier = 0, er;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0000_0000, rd, data_q;
    logic [3:0] MAC_TXD = 4'h0;
    wire [31:0] PRDATA;
    wire [3:0] PHY_TXD, PHY_RXD;
    wire PREADY, PSLVERR, TX_CLK, MAC_CRS, MAC_COL, PHY_TX_EN, PHY_TX_ER;
    wire PHY_CRS, PHY_COL, PHY_RX_DV, PHY_RX_ER;
    int n_mismatch = 0, num_checks = 0, n_mark, n_mstart, n_claim, n_data, base;
    mtsc_top #(.SLOT_TICKS(16'h0004), .SILENCE_TICKS(16'h0008), .EARLY_RX_TICKS(16'h0004),
        .MARKER_TICKS(16'h0002), .MAX_NODE_COUNT(8'h03)) i_dut (
        .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .TX_CLK(TX_CLK), .MAC_TXD(MAC_TXD), .MAC_TX_EN(MAC_TX_EN), .MAC_TX_ER(MAC_TX_ER),
        .MAC_CRS(MAC_CRS), .MAC_COL(MAC_COL), .PHY_TXD(PHY_TXD), .PHY_TX_EN(PHY_TX_EN),
        .PHY_TX_ER(PHY_TX_ER), .PHY_CRS(PHY_CRS), .PHY_COL(PHY_COL), .PHY_RX_DV(PHY_RX_DV),
        .PHY_RX_ER(PHY_RX_ER), .PHY_RXD(PHY_RXD));
    mtsc_phy_model i_phy (.txd(PHY_TXD), .tx_en(PHY_TX_EN), .tx_er(PHY_TX_ER),
        .carrier(carrier), .tx_clk(TX_CLK), .crs(PHY_CRS), .col(PHY_COL), .rx_dv(PHY_RX_DV),
        .rx_er(PHY_RX_ER), .rxd(PHY_RXD), .n_mark(n_mark), .n_mstart(n_mstart),
        .n_claim(n_claim), .n_data(n_data), .data_q(data_q));
    always #2.5 CLOCK = ~CLOCK;
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK) PENABLE <= 1'b1;
        do @(posedge CLOCK); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLOCK);
    endtask
    task ticks(input int n);
        repeat (n * 32) @(posedge CLOCK);
    endtask
    // align to n transmit clock periods after the start of the next cycle marker
    task wait_mark(input int n);
        base = n_mstart;
        for (int k = 0; k < 30000 && n_mstart == base; k++) @(posedge CLOCK);
        ticks(n);
    endtask
    // mac stops when its frame ends, jam included
    task mac_frame(input int n, input int bad);
        for (int i = 0; i <= n; i++) begin
            @(posedge TX_CLK);
            @(posedge CLOCK);
            MAC_TX_EN <= i < n;
            MAC_TX_ER <= i == bad;
            MAC_TXD <= 4'(i + 1);
        end
    endtask
    task status;
        apb(1'b0, `MTSC_STATUS_OFFSET, 32'h0000_0000);
    endtask
    task t_regs;
        apb(1'b0, `MTSC_CTRL_OFFSET, 32'h0000_0000);
        `CHK("ctrl", 32'h0000_0000, rd)
        status;
        `CHK("status", 32'h0000_0000, rd)
        apb(1'b1, 8'h08, 32'hffff_ffff);
        `CHK("slverr", 1'b1, er)
        apb(1'b0, 8'h08, 32'h0000_0000);
        `CHK("unmapped", 32'h0000_0000, rd)
    endtask
    task t_pass;
        base = n_data;
        mac_frame(3, -1);
        ticks(3);
        `CHK("pass count", base + 3, n_data)
        `CHK("pass data", 12'h123, data_q[11:0])
        carrier <= 1'b1;
        ticks(2);
        `CHK("pass crs", 1'b1, MAC_CRS)
        carrier <= 1'b0;
        ticks(2);
    endtask
    task t_marker;
        apb(1'b1, `MTSC_CTRL_OFFSET, 32'h0000_0001);
        wait_mark(3);
        `CHK("marker ticks", 2, n_mark)
        status;
        `CHK("sync state", 17'h0_0005, rd[16:0])
    endtask
    task t_send;
        wait_mark(7);
        base = n_data;
        fork
            mac_frame(6, -1);
            begin
                ticks(2);
                status;
                `CHK("hold", 4'h9, {rd[16], rd[6:4]})
            end
        join
        for (int k = 0; k < 30000 && n_data < base + 6; k++) @(posedge CLOCK);
        ticks(1);
        `CHK("sent data", 24'h12_3456, data_q[23:0])
        `CHK("claim", 1'b1, n_claim > 0)
    endtask
    task t_abort;
        wait_mark(7);
        base = n_data;
        mac_frame(4, 1);
        ticks(20);
        `CHK("abort sent", base, n_data)
        status;
        `CHK("abort state", 4'h0, {rd[16], rd[6:4]})
    endtask
    task t_collide;
        wait_mark(7);
        base = n_data;
        fork
            mac_frame(4, -1);
            begin
                ticks(1);
                carrier <= 1'b1;
                ticks(2);
                status;
                `CHK("collide", 9'h047, {rd[16], rd[7:0]})
                `CHK("col crs", 2'b11, {MAC_COL, MAC_CRS})
            end
        join
        ticks(1);
        status;
        `CHK("pending", 5'h1d, {MAC_CRS, rd[16], rd[6:4]})
        carrier <= 1'b0;
        for (int k = 0; k < 30000 && MAC_CRS !== 1'b0; k++) @(posedge CLOCK);
        `CHK("crs off", 1'b0, MAC_CRS)
        `CHK("nothing sent", base, n_data)
        mac_frame(2, -1);
        for (int k = 0; k < 30000 && n_data < base + 2; k++) @(posedge CLOCK);
        ticks(1);
        `CHK("resent", 8'h12, data_q[7:0])
    endtask
    task finish_test;
        if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge CLOCK);
        RST_N <= 1'b1;
        repeat (8) @(posedge CLOCK);
        t_regs;
        t_pass;
        t_marker;
        t_send;
        t_abort;
        t_collide;
        apb(1'b1, `MTSC_CTRL_OFFSET, 32'h0000_0000);
        ticks(2);
        status;
        `CHK("disabled", 32'h0000_0000, rd)
        finish_test;
    end
    initial begin
        #400_000;
        n_mismatch++;
        finish_test;
    end
endmodule // testbench
